// >>> shared/scaler_mode_pkg.sv
// Constants for the overlay window one scaling and edge-enhancement mode control.
// Assumes one 50 MHz system clock and an APB master with 32-bit data.
package scaler_mode_pkg;

    // ****************************************************************
    // Bus layout
    // ****************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int MODE_W = 16;
    localparam logic [ADDR_W-1:0] MODE_OFFSET = 12'h260;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h264;

    // ****************************************************************
    // Mode register fields
    // ****************************************************************
    localparam logic [MODE_W-1:0] MODE_RESET = 16'h0000;
    localparam logic [MODE_W-1:0] MODE_WMASK = 16'h87AA;
    localparam int HFILT_BIT = 1;
    localparam int HSCALE_BIT = 3;
    localparam int VFILT_BIT = 5;
    localparam int VSCALE_BIT = 7;
    localparam int STRENGTH_LSB = 8;
    localparam int STRENGTH_W = 3;
    localparam int ENHANCE_BIT = 15;

    // ****************************************************************
    // Status register fields (read only)
    // ****************************************************************
    localparam int ST_HSCALE_BIT = 0;
    localparam int ST_HINTERP_BIT = 1;
    localparam int ST_VSCALE_BIT = 2;
    localparam int ST_VINTERP_BIT = 3;
    localparam int ST_ENHANCE_BIT = 4;
    localparam int ST_CONFLICT_BIT = 5;
    localparam int ST_STRENGTH_LSB = 8;

    typedef enum logic [1:0] {
        FILT_REPLICATE = 2'h0,
        FILT_INTERP = 2'h1
    } filter_mode_t;

endpackage

// >>> shared/scale_mode_if.sv
// Carrier between the mode register and its decoder.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
`default_nettype none
interface scale_mode_if;
    logic [scaler_mode_pkg::MODE_W-1:0] mode;
    logic transparency_on;
    logic hscale_en;
    logic vscale_en;
    scaler_mode_pkg::filter_mode_t hfilter;
    scaler_mode_pkg::filter_mode_t vfilter;
    logic enhance_en;
    logic [scaler_mode_pkg::STRENGTH_W-1:0] strength;
    logic filter_conflict;

    modport owner (
        output mode,
        output transparency_on,
        input hscale_en,
        input vscale_en,
        input hfilter,
        input vfilter,
        input enhance_en,
        input strength,
        input filter_conflict
    );
    modport decoder (
        input mode,
        input transparency_on,
        output hscale_en,
        output vscale_en,
        output hfilter,
        output vfilter,
        output enhance_en,
        output strength,
        output filter_conflict
    );
endinterface
`default_nettype wire

// >>> design/scale_mode_decode.sv
// Field decoder for the overlay window one scaling mode word.
// Assumes the word is already registered; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module scale_mode_decode (
    // Mode word in, decoded controls out
    scale_mode_if.decoder mif
);
    always_comb begin
        mif.hscale_en = mif.mode[scaler_mode_pkg::HSCALE_BIT];
        mif.vscale_en = mif.mode[scaler_mode_pkg::VSCALE_BIT];
        mif.hfilter = mif.mode[scaler_mode_pkg::HFILT_BIT] ?
            scaler_mode_pkg::FILT_INTERP : scaler_mode_pkg::FILT_REPLICATE;
        mif.vfilter = mif.mode[scaler_mode_pkg::VFILT_BIT] ?
            scaler_mode_pkg::FILT_INTERP : scaler_mode_pkg::FILT_REPLICATE;
        mif.enhance_en = mif.mode[scaler_mode_pkg::ENHANCE_BIT];
        // Strength is forced to zero while enhancement is off, so the
        // datapath never sees a stale strength
        if (mif.mode[scaler_mode_pkg::ENHANCE_BIT]) begin
            mif.strength = mif.mode[scaler_mode_pkg::STRENGTH_LSB +:
                scaler_mode_pkg::STRENGTH_W];
        end else begin
            mif.strength = '0;
        end
        // Flags an interpolating filter under transparency; hardware obeys
        // the register anyway, software is expected to avoid this
        mif.filter_conflict = mif.transparency_on &
            (mif.mode[scaler_mode_pkg::HFILT_BIT] |
             mif.mode[scaler_mode_pkg::VFILT_BIT]);
    end
endmodule
`default_nettype wire

// >>> design/overlay_scaler_mode_control.sv
// Scaling and edge-enhancement mode control for overlay window one.
// Assumes an APB master on clk; transparency_on comes from logic on clk.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module overlay_scaler_mode_control (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [scaler_mode_pkg::ADDR_W-1:0] paddr,
    input wire logic [scaler_mode_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [scaler_mode_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Window one transparency state
    input wire logic transparency_on,
    // Scaler datapath controls
    output logic hscale_en,
    output logic hfilter_interp,
    output logic vscale_en,
    output logic vfilter_interp,
    output logic enhance_en,
    output logic [scaler_mode_pkg::STRENGTH_W-1:0] enhance_strength,
    output logic filter_conflict
);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic setup;
    logic access;
    logic hit_mode;
    logic hit_status;
    logic [scaler_mode_pkg::MODE_W-1:0] mode_reg;
    logic [scaler_mode_pkg::MODE_W-1:0] mode_next;
    logic [scaler_mode_pkg::MODE_W-1:0] lane_mask;
    logic [scaler_mode_pkg::DATA_W-1:0] status_word;
    logic pready_reg;
    logic pslverr_reg;
    logic [scaler_mode_pkg::DATA_W-1:0] prdata_reg;
    scale_mode_if mif ();

    assign setup = psel & ~penable & ~pready_reg;
    assign access = psel & penable & pready_reg;
    assign hit_mode = (paddr == scaler_mode_pkg::MODE_OFFSET);
    assign hit_status = (paddr == scaler_mode_pkg::STATUS_OFFSET);
    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & scaler_mode_pkg::MODE_WMASK;
    assign mode_next = (mode_reg & ~lane_mask) |
        (pwdata[scaler_mode_pkg::MODE_W-1:0] & lane_mask);

    // ****************************************************************
    // Bus handshake: one wait-free access phase after each setup
    // ****************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            // Unmapped addresses and writes to the status word fail
            pslverr_reg <= setup & ~(hit_mode | (hit_status & ~pwrite));
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_reg <= '0;
        end else if (setup) begin
            if (pwrite) begin
                prdata_reg <= '0;
            end else if (hit_mode) begin
                prdata_reg <= {{(scaler_mode_pkg::DATA_W - scaler_mode_pkg::MODE_W){1'b0}},
                    mode_reg};
            end else if (hit_status) begin
                prdata_reg <= status_word;
            end else begin
                prdata_reg <= '0;
            end
        end
    end

    // ****************************************************************
    // Mode register
    // ****************************************************************
    // Reserved bits are masked out so they always read back as zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg <= scaler_mode_pkg::MODE_RESET;
        end else if (access & pwrite & hit_mode) begin
            mode_reg <= mode_next;
        end
    end

    assign mif.mode = mode_reg;
    assign mif.transparency_on = transparency_on;

    scale_mode_decode u_decode (
        .mif(mif.decoder)
    );

    always_comb begin
        status_word = '0;
        status_word[scaler_mode_pkg::ST_HSCALE_BIT] = hscale_en;
        status_word[scaler_mode_pkg::ST_HINTERP_BIT] = hfilter_interp;
        status_word[scaler_mode_pkg::ST_VSCALE_BIT] = vscale_en;
        status_word[scaler_mode_pkg::ST_VINTERP_BIT] = vfilter_interp;
        status_word[scaler_mode_pkg::ST_ENHANCE_BIT] = enhance_en;
        status_word[scaler_mode_pkg::ST_CONFLICT_BIT] = filter_conflict;
        status_word[scaler_mode_pkg::ST_STRENGTH_LSB +: scaler_mode_pkg::STRENGTH_W] =
            enhance_strength;
    end

    // ****************************************************************
    // Datapath controls, registered so they change one edge after a write
    // ****************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hscale_en <= 1'b0;
            hfilter_interp <= 1'b0;
            vscale_en <= 1'b0;
            vfilter_interp <= 1'b0;
            enhance_en <= 1'b0;
            enhance_strength <= '0;
            filter_conflict <= 1'b0;
        end else begin
            hscale_en <= mif.hscale_en;
            hfilter_interp <= (mif.hfilter == scaler_mode_pkg::FILT_INTERP);
            vscale_en <= mif.vscale_en;
            vfilter_interp <= (mif.vfilter == scaler_mode_pkg::FILT_INTERP);
            enhance_en <= mif.enhance_en;
            enhance_strength <= mif.strength;
            filter_conflict <= mif.filter_conflict;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

endmodule
`default_nettype wire

// >>> tb/overlay_scaler_mode_sva.sv
// Port checker for the overlay window one mode control.
// Assumes zero-wait APB answers and controls one clock behind the register.
`timescale 1ns/1ps
`default_nettype none
module overlay_scaler_mode_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [scaler_mode_pkg::ADDR_W-1:0] paddr,
    input wire logic [scaler_mode_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    // Controls
    input wire logic transparency_on,
    input wire logic hscale_en,
    input wire logic hfilter_interp,
    input wire logic vscale_en,
    input wire logic vfilter_interp,
    input wire logic enhance_en,
    input wire logic [scaler_mode_pkg::STRENGTH_W-1:0] enhance_strength,
    input wire logic filter_conflict
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic wr_ok;
    logic bad_adr;
    assign wr_ok = psel && penable && pready && !pslverr && pwrite
        && paddr == scaler_mode_pkg::MODE_OFFSET;
    assign bad_adr = paddr != scaler_mode_pkg::MODE_OFFSET
        && paddr != scaler_mode_pkg::STATUS_OFFSET;
    ready_timing_a: assert property (psel && !penable |=> pready) else $error("late ready");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    bad_addr_err_a: assert property (psel && !penable && bad_adr |=> pslverr)
        else $error("no error on unmapped address");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    hscale_track_a: assert property (wr_ok && pstrb[0] |=> ##1
        hscale_en == $past(pwdata[3], 2))
        else $error("hscale wrong");
    hfilt_track_a: assert property (wr_ok && pstrb[0] |=> ##1
        hfilter_interp == $past(pwdata[1], 2))
        else $error("hfilter wrong");
    vscale_track_a: assert property (wr_ok && pstrb[0] |=> ##1
        vscale_en == $past(pwdata[7], 2))
        else $error("vscale wrong");
    vfilt_track_a: assert property (wr_ok && pstrb[0] |=> ##1
        vfilter_interp == $past(pwdata[5], 2))
        else $error("vfilter wrong");
    strength_gate_a: assert property (wr_ok && pstrb[1] |=> ##1 enhance_en == $past(pwdata[15], 2)
        && enhance_strength == ($past(pwdata[15], 2) ? $past(pwdata[10:8], 2) : 3'h0))
        else $error("enhancement wrong");
    conflict_off_a: assert property (!$past(transparency_on) |-> !filter_conflict)
        else $error("conflict without transparency");
    cover property (wr_ok && pstrb[1]);
    cover property (pslverr);
    cover property (filter_conflict);
endmodule
bind overlay_scaler_mode_control overlay_scaler_mode_sva chk_u (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .transparency_on(transparency_on),
    .hscale_en(hscale_en), .hfilter_interp(hfilter_interp), .vscale_en(vscale_en),
    .vfilter_interp(vfilter_interp), .enhance_en(enhance_en),
    .enhance_strength(enhance_strength), .filter_conflict(filter_conflict));
`default_nettype wire

// >>> tb/overlay_scaler_mode_control_bench.sv
// Self-checking bench for the overlay window one mode control.
// Assumes the bench alone drives the APB port and the transparency input.
`timescale 1ns/1ps
`default_nettype none
module overlay_scaler_mode_control_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, transparency_on = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, err, hs, hf, vs, vf, en, fc;
    logic [2:0] st;
    logic [15:0] m;
    int n_mismatch = 0;
    int comparisons = 0;
    // Rows: value written, value read back (reserved bits drop out)
    logic [15:0] rows [9][2] = '{'{16'hFFFF, 16'h87AA}, '{16'h0008, 16'h0008},
        '{16'h0002, 16'h0002}, '{16'h0080, 16'h0080}, '{16'h0020, 16'h0020},
        '{16'h0100, 16'h0100}, '{16'h8100, 16'h8100}, '{16'h8700, 16'h8700},
        '{16'h0000, 16'h0000}};
    overlay_scaler_mode_control dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .transparency_on(transparency_on),
        .hscale_en(hs), .hfilter_interp(hf), .vscale_en(vs), .vfilter_interp(vf),
        .enhance_en(en), .enhance_strength(st), .filter_conflict(fc));
    always #10 clk = ~clk;
    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        // No cycle limit here: only the watchdog ends a missing answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, 12'h260, 32'h0, 4'h0);
        chk(rd, 32'h0);
        chk({22'h0, err, hs, hf, vs, vf, en, st, fc}, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, 12'h260, {16'h0, rows[i][0]}, 4'hF);
            apb(1'b0, 12'h260, 32'h0, 4'h0);
            chk(rd, {16'h0, rows[i][1]});
            m = rows[i][1];
            chk({24'h0, hs, hf, vs, vf, en, st}, {24'h0, m[3], m[1], m[7], m[5], m[15],
                (m[15] ? m[10:8] : 3'h0)});
            apb(1'b0, 12'h264, 32'h0, 4'h0);
            chk(rd, {21'h0, (m[15] ? m[10:8] : 3'h0), 3'h0, m[15], m[5], m[7], m[1], m[3]});
            chk({31'h0, err}, 32'h0);
        end
        apb(1'b1, 12'h260, 32'hFFFF, 4'h1);
        apb(1'b0, 12'h260, 32'h0, 4'h0);
        chk(rd, 32'h00AA);
        apb(1'b1, 12'h264, 32'hFFFF, 4'hF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h268, 32'h0, 4'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h260, 32'h0, 4'h0);
        chk(rd, 32'h00AA);
        transparency_on <= 1'b1;
        repeat (2) @(posedge clk);
        chk({29'h0, fc, hf, vf}, 32'h7);
        // Status shows all four scaler controls plus the conflict flag
        apb(1'b0, 12'h264, 32'h0, 4'h0);
        chk(rd, 32'h0000002F);
        apb(1'b1, 12'h260, 32'h0, 4'hF);
        repeat (2) @(posedge clk);
        chk({29'h0, fc, hf, vf}, 32'h0);
        apb(1'b1, 12'h260, 32'h8788, 4'hF);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, 12'h260, 32'h0, 4'h0);
        chk(rd, 32'h0);
        chk({26'h0, hs, vs, en, st}, 32'h0);
        summarize();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire
